/* hw/cbspc_map.vh */
// Constants for the cell balance stop and pause controller
// Overview of operation
// RQ1: Go starts balancing on channels with nonzero timers; running flag raised while active.
// RQ2: A nonzero stop threshold applies to every channel alike.
// RQ3: A channel stops at timer expiry or voltage under threshold, whichever first.
// RQ4: Below-threshold indication comes from the undervoltage comparator path only.
// RQ5: Host writes threshold, starts undervoltage protector round robin, then issues go.
// RQ6: New threshold is latched on protector restart; no new go needed.
// RQ7: With fault stop enabled, an unmasked fault ends all channels and sets abort flag.
// RQ8: Balancing started in ACTIVE keeps running after moving to SLEEP.
// RQ9: All channels finished sets completion flag and applies power action; 0b10 shuts down.
// RQ10: Pause on die overtemperature, enabled thermistor overtemperature, or host pause bit.
// RQ11: Host may set the pause bit any time after balancing began.
// RQ12: During pause all switches off, all countdowns frozen, pause flag set.
// RQ13: An unmasked fault during pause does not abort balancing.
// RQ14: After pause, countdown continues and channels with nonzero timers resume.
// RQ15: Completion flag set only when every channel ended by timer or voltage.
// RQ16: Host forces stop with a zero timer or high threshold, then go.
// RQ17: Go with all timers zero does not start and leaves completion clear.
// RQ18: Nonzero timer with threshold above all voltages starts, stops at once, sets completion.
// RQ19: Six timers load on start, count down, hold while paused.
// RQ20: Capture copies selected channel's remaining time into readback.
// RQ21: Readback is meaningful while running, paused or validly stopped.
// RQ22: Readback shows 0x7f or 0xff while configuration holds balancing stopped; the code returns 0x7f only.
// RQ23: Readback shows zero after timer expiry, leftover after voltage or fault stop.
// RQ24: Die pause trips on any sensor over limit; resumes when all below limit minus hysteresis.
// RQ25: A channel's voltage stop is sticky until the next go.
`ifndef CBSPC_MAP_VH
`define CBSPC_MAP_VH
`define CBSPC_NCH         6
`define CBSPC_TW          8
`define CBSPC_INVALID_RB  8'h7f
`define CBSPC_ACT_SHUTDN  2'h2
`define CBSPC_ACT_SLEEP   2'h1
`define CBSPC_TICK_NS     1000000
`define CBSPC_CLK_NS      10
`define CBSPC_TICK_CYC    (`CBSPC_TICK_NS / `CBSPC_CLK_NS)
`endif

/* hw/cbspc_ctrl.v */
// Cell balance stop, pause, resume and remaining-time control
`timescale 1ns/1ps
`include "cbspc_map.vh"
module cbspc_ctrl #(
   parameter TICK_CYC = `CBSPC_TICK_CYC
) (
   input  wire        CORE_CLK,
   input  wire        RST_N,
   input  wire        BALANCING_GO_BIT,
   input  wire [47:0] CHANNEL_BALANCE_TIME,
   input  wire        STOP_VOLTAGE_ENABLE,
   input  wire [5:0]  STOP_VOLTAGE_DETECTION,
   input  wire        FAULT_STOP_ENABLE,
   input  wire        UNMASKED_FAULT,
   input  wire [1:0]  COMPLETION_POWER_ACTION,
   input  wire        HOST_PAUSE_REQUEST,
   input  wire        DIE_TEMP_OVER_LIMIT,
   input  wire        DIE_TEMP_BELOW_HYST,
   input  wire        THERMISTOR_PAUSE_ENABLE,
   input  wire        THERMISTOR_OVER_THRESHOLD,
   input  wire [3:0]  REMAINING_TIME_CHANNEL_SELECT,
   input  wire        REMAINING_TIME_CAPTURE,
   output wire [5:0]  BALANCE_SWITCH,
   output wire        BALANCING_ACTIVE_FLAG,
   output wire        PAUSE_ACTIVE_FLAG,
   output wire        BALANCING_COMPLETE_FLAG,
   output wire        FAULT_ABORT_FLAG,
   output wire        SHUTDOWN_REQUEST,
   output wire        SLEEP_REQUEST,
   output wire [7:0]  REMAINING_TIME_READBACK
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_RUN   = 2'h1;
   localparam ST_STOP  = 2'h2;
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [47:0] timer_q;
   reg  [5:0]  vstop_q;
   reg  [5:0]  vdet_m_q;
   reg  [5:0]  vdet_q;
   reg  [4:0]  async_m_q;
   reg  [4:0]  async_q;
   reg         die_pause_q;
   reg         complete_q;
   reg         abort_q;
   reg         shut_q;
   reg         sleep_q;
   reg  [7:0]  readback_q;
   reg  [31:0] tick_cnt_q;
   reg         go_q;
   reg         cap_q;
   wire        go_pulse;
   wire        cap_pulse;
   wire        tick;
   wire        pause;
   wire        fault;
   wire [5:0]  live;
   wire        all_zero;
   // Pin inputs pass two flops
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         vdet_m_q  <= 6'h00;
         vdet_q    <= 6'h00;
         async_m_q <= 5'h00;
         async_q   <= 5'h00;
      end
      else
      begin
         vdet_m_q  <= STOP_VOLTAGE_DETECTION; // [RQ4]
         vdet_q    <= vdet_m_q;
         async_m_q <= {UNMASKED_FAULT, DIE_TEMP_OVER_LIMIT, DIE_TEMP_BELOW_HYST,
                       THERMISTOR_OVER_THRESHOLD, 1'b0};
         async_q   <= async_m_q;
      end
   end
   assign go_pulse  = BALANCING_GO_BIT & ~go_q;
   assign cap_pulse = REMAINING_TIME_CAPTURE & ~cap_q;
   assign tick      = (tick_cnt_q == TICK_CYC - 1);
   // Three pause sources
   assign pause = die_pause_q | (THERMISTOR_PAUSE_ENABLE & async_q[1]) |
                  HOST_PAUSE_REQUEST; // [RQ10] [RQ11]
   assign fault = FAULT_STOP_ENABLE & async_q[4] & ~pause; // [RQ7] [RQ13]
   assign all_zero = (CHANNEL_BALANCE_TIME == 48'h0);
   genvar g;
   generate
      for (g = 0; g < `CBSPC_NCH; g = g + 1)
      begin : g_ch
         assign live[g] = (timer_q[g*8 +: 8] != 8'h00) & ~vstop_q[g]; // [RQ3]
         assign BALANCE_SWITCH[g] = (state_q == ST_RUN) & live[g] & ~pause; // [RQ12] [RQ14]
         always @(posedge CORE_CLK or negedge RST_N)
         begin
            if (!RST_N)
            begin
               timer_q[g*8 +: 8] <= 8'h00;
               vstop_q[g]        <= 1'b0;
            end
            else if (go_pulse)
            begin
               timer_q[g*8 +: 8] <= CHANNEL_BALANCE_TIME[g*8 +: 8]; // [RQ19] [RQ16]
               vstop_q[g]        <= 1'b0;
            end
            else if (state_q == ST_RUN && !pause && live[g])
            begin
               if (STOP_VOLTAGE_ENABLE && vdet_q[g])
                  vstop_q[g] <= 1'b1; // [RQ2] [RQ25] [RQ6]
               else if (tick)
                  timer_q[g*8 +: 8] <= timer_q[g*8 +: 8] - 8'h01; // [RQ19]
            end
         end
      end
   endgenerate
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: state_d = state_q;
         ST_RUN:
            if (fault || live == 6'h00)
               state_d = ST_STOP; // [RQ15]
         ST_STOP: state_d = state_q;
         default: state_d = ST_IDLE;
      endcase
      if (go_pulse)
         state_d = all_zero ? ST_IDLE : ST_RUN; // [RQ1] [RQ17] [RQ18]
   end
   always @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_q     <= ST_IDLE;
         go_q        <= 1'b0;
         cap_q       <= 1'b0;
         tick_cnt_q  <= 32'h0;
         die_pause_q <= 1'b0;
         complete_q  <= 1'b0;
         abort_q     <= 1'b0;
         shut_q      <= 1'b0;
         sleep_q     <= 1'b0;
         readback_q  <= `CBSPC_INVALID_RB;
      end
      else
      begin
         state_q <= state_d; // [RQ8]
         go_q    <= BALANCING_GO_BIT;
         cap_q   <= REMAINING_TIME_CAPTURE;
         if (go_pulse || tick || state_q != ST_RUN || pause)
            tick_cnt_q <= 32'h0;
         else
            tick_cnt_q <= tick_cnt_q + 32'h1;
         // Die pause with hysteresis
         if (state_q != ST_RUN)
            die_pause_q <= 1'b0;
         else if (async_q[3])
            die_pause_q <= 1'b1; // [RQ24]
         else if (async_q[2])
            die_pause_q <= 1'b0; // [RQ24]
         if (go_pulse)
         begin
            complete_q <= 1'b0;
            abort_q    <= 1'b0;
            shut_q     <= 1'b0;
            sleep_q    <= 1'b0;
         end
         else if (state_q == ST_RUN && fault)
            abort_q <= 1'b1; // [RQ7]
         else if (state_q == ST_RUN && live == 6'h00)
         begin
            complete_q <= 1'b1; // [RQ9] [RQ15]
            shut_q     <= (COMPLETION_POWER_ACTION == `CBSPC_ACT_SHUTDN); // [RQ9]
            sleep_q    <= (COMPLETION_POWER_ACTION == `CBSPC_ACT_SLEEP);
         end
         if (cap_pulse)
         begin
            if (state_q == ST_IDLE || REMAINING_TIME_CHANNEL_SELECT >= 4'h6)
               readback_q <= `CBSPC_INVALID_RB; // [RQ22]
            else
               readback_q <= timer_q[REMAINING_TIME_CHANNEL_SELECT*8 +: 8]; // [RQ20] [RQ21] [RQ23]
         end
      end
   end
   assign BALANCING_ACTIVE_FLAG   = (state_q == ST_RUN); // [RQ1]
   assign PAUSE_ACTIVE_FLAG       = (state_q == ST_RUN) & pause; // [RQ12]
   assign BALANCING_COMPLETE_FLAG = complete_q;
   assign FAULT_ABORT_FLAG        = abort_q;
   assign SHUTDOWN_REQUEST        = shut_q;
   assign SLEEP_REQUEST           = sleep_q;
   assign REMAINING_TIME_READBACK = readback_q;
endmodule // cbspc_ctrl

/* verification/cbspc_uv_model.sv */
// Comparator model that feeds the stop detections
`timescale 1ns/1ps
module cbspc_uv_model (
   input  wire        clk,
   input  wire        uv_go,
   input  wire [7:0]  thr,
   input  wire [47:0] vc,
   output reg  [5:0]  det
);
   reg     [7:0] thr_q = 8'h00;
   integer       i;
   always @(posedge clk)
   begin
      if (uv_go)
         thr_q <= thr;
      for (i = 0; i < 6; i = i + 1)
         det[i] <= vc[i*8+:8] < thr_q;
   end
endmodule // cbspc_uv_model

/* verification/cbspc_ctrl_monitor.sv */
// Assertion checker for the balance controller
`timescale 1ns/1ps
module cbspc_ctrl_monitor (
   input wire        CORE_CLK,
   input wire        RST_N,
   input wire        BALANCING_GO_BIT,
   input wire [47:0] CHANNEL_BALANCE_TIME,
   input wire [5:0]  STOP_VOLTAGE_DETECTION,
   input wire [1:0]  COMPLETION_POWER_ACTION,
   input wire [5:0]  BALANCE_SWITCH,
   input wire        BALANCING_ACTIVE_FLAG,
   input wire        PAUSE_ACTIVE_FLAG,
   input wire        BALANCING_COMPLETE_FLAG,
   input wire        FAULT_ABORT_FLAG,
   input wire        SHUTDOWN_REQUEST
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   property p_on; |BALANCE_SWITCH |-> BALANCING_ACTIVE_FLAG; endproperty
   a_on: assert property (p_on) else $error("switch on while idle");
   property p_off; PAUSE_ACTIVE_FLAG |-> BALANCE_SWITCH == 6'h00; endproperty
   a_off: assert property (p_off) else $error("switch on in pause");
   property p_zero; $rose(BALANCING_GO_BIT) && CHANNEL_BALANCE_TIME == 48'h0
      |-> ##2 !BALANCING_ACTIVE_FLAG && !BALANCING_COMPLETE_FLAG; endproperty
   a_zero: assert property (p_zero) else $error("zero go started");
   property p_shut; $rose(BALANCING_COMPLETE_FLAG) && COMPLETION_POWER_ACTION == 2'h2
      |-> SHUTDOWN_REQUEST; endproperty
   a_shut: assert property (p_shut) else $error("no shutdown");
   property p_sd; SHUTDOWN_REQUEST |-> BALANCING_COMPLETE_FLAG; endproperty
   a_sd: assert property (p_sd) else $error("early shutdown");
   property p_vs; (STOP_VOLTAGE_DETECTION[0] && !BALANCING_GO_BIT) [*3] |=> !BALANCE_SWITCH[0];
   endproperty
   a_vs: assert property (p_vs) else $error("voltage stop ignored");
   property p_ex; BALANCING_COMPLETE_FLAG |-> !FAULT_ABORT_FLAG; endproperty
   a_ex: assert property (p_ex) else $error("done with abort");
   property p_id; BALANCING_COMPLETE_FLAG |-> !BALANCING_ACTIVE_FLAG; endproperty
   a_id: assert property (p_id) else $error("done while active");
   c_pause: cover property (PAUSE_ACTIVE_FLAG);
   c_done: cover property ($rose(BALANCING_COMPLETE_FLAG));
   c_abort: cover property ($rose(FAULT_ABORT_FLAG));
endmodule // cbspc_ctrl_monitor
bind cbspc_ctrl cbspc_ctrl_monitor cbspc_ctrl_monitor_inst (.*);

/* verification/tb.sv */
// Self-checking bench for the balance controller
`timescale 1ns/1ps
module tb;
   reg         clk = 0, rn = 0, go = 0, fe = 0, flt = 0, hp = 0, cap = 0, ug = 0;
   reg         dto = 0, dbh = 1;
   reg  [47:0] tmr = 48'h0;
   reg  [7:0]  thr = 8'h00, held;
   reg  [3:0]  sel = 4'h0;
   wire [5:0]  sw, det;
   wire        run, psd, done, ab, sd;
   wire [7:0]  rb;
   integer     err_total = 0, checks = 0, n;
   cbspc_uv_model cbspc_uv_model_inst (.clk(clk), .uv_go(ug), .thr(thr), .vc({6{8'h80}}),
      .det(det));
   cbspc_ctrl #(.TICK_CYC(4)) cbspc_ctrl_inst (.CORE_CLK(clk), .RST_N(rn), .BALANCING_GO_BIT(go),
      .CHANNEL_BALANCE_TIME(tmr), .STOP_VOLTAGE_ENABLE(1'b1), .STOP_VOLTAGE_DETECTION(det),
      .FAULT_STOP_ENABLE(fe), .UNMASKED_FAULT(flt), .COMPLETION_POWER_ACTION(2'h2),
      .HOST_PAUSE_REQUEST(hp), .DIE_TEMP_OVER_LIMIT(dto), .DIE_TEMP_BELOW_HYST(dbh),
      .THERMISTOR_PAUSE_ENABLE(1'b0), .THERMISTOR_OVER_THRESHOLD(1'b0),
      .REMAINING_TIME_CHANNEL_SELECT(sel), .REMAINING_TIME_CAPTURE(cap), .BALANCE_SWITCH(sw),
      .BALANCING_ACTIVE_FLAG(run), .PAUSE_ACTIVE_FLAG(psd), .BALANCING_COMPLETE_FLAG(done),
      .FAULT_ABORT_FLAG(ab), .SHUTDOWN_REQUEST(sd), .SLEEP_REQUEST(),
      .REMAINING_TIME_READBACK(rb));
   task chk(input [7:0] s, input [7:0] e, input [23:0] nm);
      checks += 1;
      if (s !== e)
      begin
         err_total += 1;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task tick(input integer k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task kick;
      go <= 1;
      tick(1);
      go <= 0;
      tick(1);
   endtask
   task grab(input [3:0] c);
      sel <= c;
      cap <= 1;
      tick(1);
      cap <= 0;
      tick(2);
   endtask
   task print_verdict;
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial forever #5 clk = ~clk;
   initial
   begin
      #20000;
      err_total += 1;
      print_verdict;
   end
   initial
   begin
      tick(2);
      rn <= 1;
      grab(4'h0);
      chk(rb, 8'h7f, "rb0");
      kick;
      chk({run, done}, 8'h00, "go0");
      grab(4'h0);
      chk(rb, 8'h7f, "rb1");
      tmr <= 48'h0403;
      kick;
      chk(sw, 8'h03, "sw");
      hp <= 1;
      tick(2);
      chk({sw, psd}, 8'h01, "hp");
      grab(4'h1);
      held = rb;
      tick(20);
      grab(4'h1);
      chk(rb, held, "frz");
      hp <= 0;
      tick(2);
      chk(sw, 8'h03, "res");
      dto <= 1;
      dbh <= 0;
      tick(4);
      chk({sw, psd}, 8'h01, "dtp");
      dto <= 0;
      tick(4);
      chk(psd, 8'h01, "hys");
      dbh <= 1;
      tick(4);
      chk({sw, psd}, 8'h06, "dtr");
      n = 0;
      while (done !== 1'b1 && n++ < 99) tick(1);
      chk({done, sd, ab}, 8'h06, "end");
      grab(4'h0);
      chk(rb, 8'h00, "exp");
      thr <= 8'hff;
      ug <= 1;
      tick(1);
      ug <= 0;
      tmr <= 48'h40;
      tick(4);
      kick;
      tick(6);
      chk({done, run}, 8'h02, "vs");
      grab(4'h0);
      chk(rb > 8'h30, 8'h01, "lft");
      thr <= 8'h00;
      ug <= 1;
      tick(1);
      ug <= 0;
      tick(4);
      fe <= 1;
      tmr <= 48'h40_0000;
      kick;
      hp <= 1;
      flt <= 1;
      tick(9);
      chk(ab, 8'h00, "pf");
      hp <= 0;
      tick(9);
      chk({ab, done, sw}, 8'h80, "ab");
      print_verdict;
   end
endmodule // tb
